// File: hdl/cell_adc_map.svh
// register offsets, field positions, reset values and counts
`ifndef CELL_ADC_MAP_SVH
`define CELL_ADC_MAP_SVH
`define OFS_CORR_H      3'h0
`define OFS_CORR_L      3'h1
`define OFS_FILT_H      3'h2
`define OFS_FILT_L      3'h3
`define OFS_RAW_H       3'h4
`define OFS_RAW_M       3'h5
`define OFS_RAW_L       3'h6
`define ADDR_DIE_H      8'h30
`define ADDR_DIE_L      8'h31
`define ADDR_AUX_H      8'h32
`define ADDR_AUX_L      8'h33
`define ADDR_CFG_CELL   8'h40
`define ADDR_CFG_AUX    8'h41
`define ADDR_DIAG       8'h42
`define ADDR_CTRL       8'h43
`define ADDR_DELAY      8'h44
`define ADDR_TRIM       8'h45
`define ADDR_STATUS     8'h46
`define F_DR            1:0
`define F_SHIFT         4:2
`define F_TRIM          3:0
`define B_FILT_SEL      0
`define B_UNC_SEL       1
`define B_CELL_GO       0
`define B_AUX_GO        1
`define B_CONT          2
`define CFG_DR_RST      2'h3
`define PRESET16        16'h8000
`define PRESET24        24'h800000
`define LAST_OUTPUT     3'h3
`define FILT_SHIFT_BASE 4'h2
`define BASE_RATIO      9'h020
`endif

// File: hdl/cell_adc_pkg.sv
// shared types of the cell converter back end
package cell_adc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} conv_state_type;
  typedef struct packed {
    logic [23:0] raw;
    logic [15:0] corr;
    logic [15:0] filt;
  } cell_result_type;
  typedef struct packed {
    logic [1:0] dr;
    logic [2:0] shift;
    logic [1:0] aux_dr;
    logic       filt_en;
    logic       unc_sel;
    logic       cont;
    logic [7:0] delay;
    logic [3:0] trim;
  } conv_cfg_type;
endpackage

// File: hdl/cic3_decimator.sv
// third-order cascaded integrator-comb decimator for one bitstream
`timescale 1ns/10ps
`include "cell_adc_map.svh"
module cic3_decimator #(
  parameter int ACC_W = 26,
  parameter int OUT_W = 24
) (
  input  wire logic                    clock,
  input  wire logic                    resetn,
  input  wire logic                    clear,
  input  wire logic                    mod_en,
  input  wire logic                    bit_in,
  input  wire logic [1:0]              ratio_sel,
  output logic                         out_valid,
  output logic signed [OUT_W-1:0]      out_data
);
  localparam int WW = ACC_W + 9;
  localparam logic signed [WW-1:0] OUT_MAX = WW'(2**(OUT_W-1) - 1);
  localparam logic signed [WW-1:0] OUT_MIN = -OUT_MAX - WW'(1);

  // ratio 256 grows the word by 24 bits plus sign
  if (ACC_W < 25 || OUT_W > ACC_W) begin : g_bad_width
    $error("cic3_decimator: accumulator too narrow");
  end

  logic signed [ACC_W-1:0] integ_r [3];
  logic signed [ACC_W-1:0] dly_r   [3];
  logic signed [ACC_W-1:0] comb    [3];
  logic signed [ACC_W-1:0] step;
  logic        [8:0]       cnt_r;
  logic        [8:0]       last_cnt;
  logic                    dec_tick;
  logic        [3:0]       norm_sh;
  logic signed [WW-1:0]    wide;
  logic signed [OUT_W-1:0] sat;

  assign step     = bit_in ? ACC_W'(1) : '1;
  assign last_cnt = (`BASE_RATIO << ratio_sel) - 9'h001;  // [RULE1]
  assign dec_tick = mod_en && cnt_r == last_cnt;

  // integrators at modulator rate; wrap-around is harmless in a CIC
  always_ff @(posedge clock) begin
    if (!resetn || clear) begin
      for (int i = 0; i < 3; i++) integ_r[i] <= '0;
    end else if (mod_en) begin
      integ_r[0] <= integ_r[0] + step;  // [RULE2]
      for (int i = 1; i < 3; i++) integ_r[i] <= integ_r[i] + integ_r[i-1];
    end
  end

  // decimation switch
  always_ff @(posedge clock) begin
    if (!resetn || clear) begin
      cnt_r <= '0;
    end else if (mod_en) begin
      cnt_r <= dec_tick ? 9'h000 : cnt_r + 9'h001;
    end
  end

  // combs and scaling so every ratio spans the same 24-bit range
  always_comb begin
    comb[0] = integ_r[2] - dly_r[0];  // [RULE2]
    comb[1] = comb[0] - dly_r[1];
    comb[2] = comb[1] - dly_r[2];
    norm_sh = {2'b00, 2'h3 - ratio_sel} * 4'h3;
    wide    = WW'(comb[2]) <<< norm_sh;
    if (wide > OUT_MAX) begin
      sat = OUT_MAX[OUT_W-1:0];
    end else if (wide < OUT_MIN) begin
      sat = OUT_MIN[OUT_W-1:0];
    end else begin
      sat = wide[OUT_W-1:0];
    end
  end

  // comb delays run at the decimated rate only
  always_ff @(posedge clock) begin
    if (!resetn || clear) begin
      for (int i = 0; i < 3; i++) dly_r[i] <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= dec_tick;
      if (dec_tick) begin
        dly_r[0] <= integ_r[2];
        dly_r[1] <= comb[0];
        dly_r[2] <= comb[1];
        out_data <= sat;
      end
    end
  end

  cic_tick_a: assert property (@(posedge clock) disable iff (!resetn)
    dec_tick && !clear |=> out_valid ##1 !out_valid)  // [RULE2]
    else $error("decimated output did not follow the switch");
  cic_clear_a: assert property (@(posedge clock) disable iff (!resetn)
    clear |=> integ_r[2] == '0 && !out_valid)  // [RULE1]
    else $error("clear did not restart the decimator");
endmodule

// File: hdl/cell_adc_backend.sv
// cell converter back end: decimation, correction, lowpass, results
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`include "cell_adc_map.svh"
// Functional notes
// RULE1: two-bit code picks ratio 32 to 256
// RULE2: third-order CIC, integrators then combs
// RULE3: conversion time grows with decimation ratio
// RULE4: reference correction right after decimation
// RULE5: raw decimated value stays readable
// RULE6: die converter shares the cell ratio
// RULE7: lowpass built from shifts and adds
// RULE8: lowpass input is the corrected value
// RULE9: lowpass forces continuous, minimum interval
// RULE10: high-byte read refreshes all channel results
// RULE11: three-bit field sets lowpass corner
// RULE12: host waits out lowpass step response
// RULE13: single or continuous with programmed delay
// RULE14: 16-bit corrected, 24-bit raw results
// RULE15: high-byte read freezes lower bytes
// RULE16: host reads high byte first
// RULE17: die sample corrects every cell result
// RULE18: filtered results in own registers
// RULE19: both selects filter raw into raw registers
// RULE20: two's complement, fixed weight per count
// RULE21: conversion start presets results to 0x80..
// RULE22: output moves by shifted input difference
module cell_adc_backend #(
  parameter int NUM_CELLS = 6,
  parameter int MOD_DIV   = 4
) (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [7:0] mod_bits,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata
);
  import cell_adc_pkg::*;

  // cells sit in 8-byte slots below the die/aux block at 0x30
  if (NUM_CELLS < 1 || NUM_CELLS > 6 || MOD_DIV < 1 || MOD_DIV > 256)
  begin : g_bad_param
    $error("cell_adc_backend: unsupported parameter value");
  end

  localparam int DIE_CH = 6;
  localparam int AUX_CH = 7;

  conv_cfg_type        cfg_r;
  conv_state_type      cell_st_r;
  logic [7:0]          bits_meta_r;
  logic [7:0]          bits_sync_r;
  logic [7:0]          mod_cnt_r;
  logic                mod_en;
  logic [7:0]          dv;
  logic signed [23:0]  cic_out [8];
  logic [7:0]          wait_cnt_r;
  logic [2:0]          out_cnt_r;
  logic [7:0]          interval;
  logic                cont_eff;
  logic                cell_go;
  logic                aux_go;
  logic                cell_start;
  logic                take;
  logic                corr_pend_r;
  logic                wr_live;
  logic                unc_path;
  logic [3:0]          fshift;
  logic signed [23:0]  die_drift;
  logic [15:0]         die_live_r;
  logic [7:0]          die_held_r;
  logic                aux_run_r;
  logic [2:0]          aux_cnt_r;
  logic signed [23:0]  aux_corr;
  logic signed [24:0]  aux_sum;
  logic [15:0]         aux_live_r;
  logic [7:0]          aux_held_r;
  logic                cell_ready_r;
  logic                aux_ready_r;
  logic                cell_hit;
  logic                high_ofs;
  logic [7:0]          cell_rd [NUM_CELLS];
  logic [7:0]          rd_nxt;

  // mod_bits come straight from the modulator pins
  always_ff @(posedge clock) begin
    if (!resetn) begin
      bits_meta_r <= 8'h00;
      bits_sync_r <= 8'h00;
    end else begin
      bits_meta_r <= mod_bits;
      bits_sync_r <= bits_meta_r;
    end
  end

  // modulator-rate enable from the system clock
  always_ff @(posedge clock) begin
    if (!resetn || mod_en) begin
      mod_cnt_r <= 8'h00;
    end else begin
      mod_cnt_r <= mod_cnt_r + 8'h01;
    end
  end
  assign mod_en = mod_cnt_r == 8'(MOD_DIV - 1);

  // software configuration
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cfg_r    <= '0;
      cfg_r.dr <= `CFG_DR_RST;
      cfg_r.aux_dr <= `CFG_DR_RST;
    end else if (reg_write) begin
      case (reg_addr)
        `ADDR_CFG_CELL: begin
          cfg_r.dr    <= reg_wdata[`F_DR];  // [RULE1]
          cfg_r.shift <= reg_wdata[`F_SHIFT];  // [RULE11]
        end
        `ADDR_CFG_AUX: cfg_r.aux_dr <= reg_wdata[`F_DR];  // [RULE1]
        `ADDR_DIAG: begin
          cfg_r.filt_en <= reg_wdata[`B_FILT_SEL];
          cfg_r.unc_sel <= reg_wdata[`B_UNC_SEL];
        end
        `ADDR_CTRL:  cfg_r.cont  <= reg_wdata[`B_CONT];
        `ADDR_DELAY: cfg_r.delay <= reg_wdata;
        `ADDR_TRIM:  cfg_r.trim  <= reg_wdata[`F_TRIM];
        default: ;
      endcase
    end
  end

  assign cell_go  = reg_write && reg_addr == `ADDR_CTRL
                    && reg_wdata[`B_CELL_GO];
  assign aux_go   = reg_write && reg_addr == `ADDR_CTRL
                    && reg_wdata[`B_AUX_GO];
  assign cont_eff = cfg_r.cont | cfg_r.filt_en;  // [RULE9]
  assign interval = cfg_r.filt_en ? 8'h00 : cfg_r.delay;  // [RULE9]
  assign unc_path = cfg_r.filt_en & cfg_r.unc_sel;  // [RULE19]
  assign fshift   = {1'b0, cfg_r.shift} + `FILT_SHIFT_BASE;  // [RULE11]

  // a restart clears every cell and the die decimator together
  assign cell_start = (cell_go && cfg_r.delay == 8'h00)
                      || (!cell_go && cell_st_r == ST_WAIT
                          && wait_cnt_r == 8'h00);  // [RULE13]
  // the fourth output is the first one with all comb delays filled,
  // so conversion time scales with the ratio
  assign take = cell_st_r == ST_RUN && dv[0] && !cell_go
                && out_cnt_r == `LAST_OUTPUT;  // [RULE3]

  // decimator per converter; die follows the cell ratio
  for (genvar ch = 0; ch < 8; ch++) begin : g_cic
    if (ch < NUM_CELLS || ch >= DIE_CH) begin : g_used
      cic3_decimator u_cic (
        .clock     (clock),
        .resetn    (resetn),
        .clear     (ch == AUX_CH ? aux_go : cell_start),
        .mod_en    (mod_en),
        .bit_in    (bits_sync_r[ch]),
        .ratio_sel (ch == AUX_CH ? cfg_r.aux_dr : cfg_r.dr),  // [RULE6]
        .out_valid (dv[ch]),
        .out_data  (cic_out[ch])
      );
    end else begin : g_unused
      assign dv[ch]      = 1'b0;
      assign cic_out[ch] = '0;
    end
  end

  // cell conversion sequencing; a go always restarts from scratch
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cell_st_r  <= ST_IDLE;
      wait_cnt_r <= 8'h00;
      out_cnt_r  <= 3'h0;
    end else if (cell_go) begin
      out_cnt_r  <= 3'h0;
      wait_cnt_r <= cfg_r.delay;  // [RULE13]
      cell_st_r  <= cfg_r.delay == 8'h00 ? ST_RUN : ST_WAIT;
    end else begin
      unique case (cell_st_r)
        ST_IDLE: begin
        end
        ST_WAIT: begin
          if (wait_cnt_r == 8'h00) begin
            cell_st_r <= ST_RUN;
            out_cnt_r <= 3'h0;
          end else if (dv[0]) begin
            wait_cnt_r <= wait_cnt_r - 8'h01;
          end
        end
        ST_RUN: begin
          if (dv[0]) begin
            out_cnt_r <= out_cnt_r + 3'h1;
            if (out_cnt_r == `LAST_OUTPUT) begin
              cell_st_r  <= cont_eff ? ST_WAIT : ST_IDLE;  // [RULE13]
              wait_cnt_r <= interval;
            end
          end
        end
      endcase
    end
  end

  // correction costs one extra cycle after the decimator
  always_ff @(posedge clock) begin
    if (!resetn) begin
      corr_pend_r <= 1'b0;
    end else begin
      corr_pend_r <= take;  // [RULE4]
    end
  end
  assign wr_live = corr_pend_r && !cell_go;

  // die sample taken in the same conversion trims drift
  assign die_drift = cic_out[DIE_CH] >>> cfg_r.trim;  // [RULE17]

  // per-cell correction, lowpass and result registers
  for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
    cell_result_type    live_r;
    cell_result_type    held_r;
    logic signed [23:0] corr_full;
    logic signed [24:0] corr_sum;
    logic        [15:0] corr16;
    logic signed [23:0] filt_r;
    logic signed [23:0] fx;
    logic signed [24:0] fdiff;
    logic signed [23:0] fnext;
    logic               hi_read;
    logic        [7:0]  rd_byte;

    // raw counts weigh 1/256 of a corrected count
    // clamp, since a full-scale result plus drift must not wrap sign
    assign corr_sum  = {cic_out[c][23], cic_out[c]}
                       + {die_drift[23], die_drift};  // [RULE4] [RULE17]
    assign corr_full = (corr_sum[24] == corr_sum[23]) ? corr_sum[23:0]
                       : (corr_sum[24] ? 24'h800000 : 24'h7FFFFF);
    assign corr16    = corr_full[23:8];  // [RULE20]

    // single pole without a multiplier: y += (x - y) >>> k
    always_comb begin
      fx    = unc_path ? cic_out[c]
                       : {{8{corr16[15]}}, corr16};  // [RULE8] [RULE19]
      fdiff = {fx[23], fx} - {filt_r[23], filt_r};
      fnext = filt_r + 24'(fdiff >>> fshift);  // [RULE7] [RULE22]
    end

    // filter state carries over conversions, like a real RC
    always_ff @(posedge clock) begin
      if (!resetn) begin
        filt_r <= '0;
      end else if (wr_live) begin
        filt_r <= fnext;  // [RULE22]
      end
    end

    // live results; a go presets so stale data is recognisable
    always_ff @(posedge clock) begin
      if (!resetn || cell_go) begin
        live_r.raw  <= `PRESET24;  // [RULE21]
        live_r.corr <= `PRESET16;
        live_r.filt <= `PRESET16;
      end else if (wr_live) begin
        live_r.raw  <= unc_path ? fnext : cic_out[c];  // [RULE5] [RULE19]
        live_r.corr <= corr16;  // [RULE14]
        live_r.filt <= unc_path ? `PRESET16 : fnext[15:0];  // [RULE18]
      end
    end

    // any high-byte read snapshots the whole channel
    assign hi_read = reg_read && cell_hit && high_ofs
                     && reg_addr[5:3] == 3'(c);
    always_ff @(posedge clock) begin
      if (!resetn) begin
        held_r <= '0;
      end else if (hi_read) begin
        held_r <= live_r;  // [RULE10] [RULE15]
      end
    end

    // high bytes read live, the rest read the snapshot
    always_comb begin
      case (reg_addr[2:0])
        `OFS_CORR_H: rd_byte = live_r.corr[15:8];  // [RULE14]
        `OFS_CORR_L: rd_byte = held_r.corr[7:0];
        `OFS_FILT_H: rd_byte = live_r.filt[15:8];
        `OFS_FILT_L: rd_byte = held_r.filt[7:0];
        `OFS_RAW_H:  rd_byte = live_r.raw[23:16];
        `OFS_RAW_M:  rd_byte = held_r.raw[15:8];
        `OFS_RAW_L:  rd_byte = held_r.raw[7:0];
        default:     rd_byte = 8'h00;
      endcase
    end
    assign cell_rd[c] = rd_byte;
  end

  // die result follows every cell conversion
  always_ff @(posedge clock) begin
    if (!resetn || cell_go) begin
      die_live_r <= `PRESET16;  // [RULE21]
    end else if (wr_live) begin
      die_live_r <= cic_out[DIE_CH][23:8];
    end
  end

  // auxiliary converter: single conversions only
  assign aux_sum  = {cic_out[AUX_CH][23], cic_out[AUX_CH]}
                    + {die_drift[23], die_drift};  // [RULE17]
  assign aux_corr = (aux_sum[24] == aux_sum[23]) ? aux_sum[23:0]
                    : (aux_sum[24] ? 24'h800000 : 24'h7FFFFF);
  always_ff @(posedge clock) begin
    if (!resetn) begin
      aux_run_r  <= 1'b0;
      aux_cnt_r  <= 3'h0;
      aux_live_r <= `PRESET16;
    end else if (aux_go) begin
      aux_run_r  <= 1'b1;
      aux_cnt_r  <= 3'h0;
      aux_live_r <= `PRESET16;  // [RULE21]
    end else if (aux_run_r && dv[AUX_CH]) begin
      aux_cnt_r <= aux_cnt_r + 3'h1;
      if (aux_cnt_r == `LAST_OUTPUT) begin
        aux_run_r  <= 1'b0;
        aux_live_r <= aux_corr[23:8];
      end
    end
  end

  // low-byte snapshots for die and aux
  always_ff @(posedge clock) begin
    if (!resetn) begin
      die_held_r <= 8'h00;
      aux_held_r <= 8'h00;
    end else if (reg_read) begin
      if (reg_addr == `ADDR_DIE_H) die_held_r <= die_live_r[7:0];  // [RULE15]
      if (reg_addr == `ADDR_AUX_H) aux_held_r <= aux_live_r[7:0];  // [RULE15]
    end
  end

  // ready flags: aux hardware set wins over aux_go; a cell go wins over the cell set
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cell_ready_r <= 1'b0;
      aux_ready_r  <= 1'b0;
    end else begin
      if (wr_live) cell_ready_r <= 1'b1;
      else if (cell_go) cell_ready_r <= 1'b0;
      if (aux_run_r && dv[AUX_CH] && aux_cnt_r == `LAST_OUTPUT)
        aux_ready_r <= 1'b1;
      else if (aux_go) aux_ready_r <= 1'b0;
    end
  end

  // read decode; unmapped addresses read zero
  assign cell_hit = reg_addr[7:6] == 2'b00 && reg_addr[5:3] < 3'(NUM_CELLS);
  assign high_ofs = reg_addr[2:0] == `OFS_CORR_H
                    || reg_addr[2:0] == `OFS_FILT_H
                    || reg_addr[2:0] == `OFS_RAW_H;
  always_comb begin
    rd_nxt = 8'h00;
    if (cell_hit) begin
      rd_nxt = cell_rd[reg_addr[5:3]];
    end else begin
      case (reg_addr)
        `ADDR_DIE_H:    rd_nxt = die_live_r[15:8];
        `ADDR_DIE_L:    rd_nxt = die_held_r;
        `ADDR_AUX_H:    rd_nxt = aux_live_r[15:8];
        `ADDR_AUX_L:    rd_nxt = aux_held_r;
        `ADDR_CFG_CELL: rd_nxt = {3'h0, cfg_r.shift, cfg_r.dr};
        `ADDR_CFG_AUX:  rd_nxt = {6'h00, cfg_r.aux_dr};
        `ADDR_DIAG:     rd_nxt = {6'h00, cfg_r.unc_sel, cfg_r.filt_en};
        `ADDR_CTRL:     rd_nxt = {5'h00, cfg_r.cont, 2'b00};
        `ADDR_DELAY:    rd_nxt = cfg_r.delay;
        `ADDR_TRIM:     rd_nxt = {4'h0, cfg_r.trim};
        `ADDR_STATUS:   rd_nxt = {4'h0, aux_ready_r, aux_run_r,
                                  cell_ready_r, cell_st_r != ST_IDLE};
        default:        rd_nxt = 8'h00;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? rd_nxt : 8'h00;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  preset_on_go_a: assert property (  // [RULE21]
    cell_go |=> g_cell[0].live_r.corr == `PRESET16
                && g_cell[0].live_r.raw == `PRESET24)
    else $error("results not preset at conversion start");
  filter_forces_cont_a: assert property (  // [RULE9]
    take && cfg_r.filt_en && !reg_write
    |=> cell_st_r == ST_WAIT ##1 cell_st_r == ST_RUN)
    else $error("lowpass did not keep conversions running");
  corr_stage_a: assert property (  // [RULE4]
    take && !reg_write ##1 !cell_go |=> cell_ready_r)
    else $error("correction stage did not complete in time");
  hold_on_high_a: assert property (  // [RULE15]
    reg_read && reg_addr == 8'h00 && !reg_write
    |=> g_cell[0].held_r == $past(g_cell[0].live_r))
    else $error("high-byte read did not freeze lower bytes");
  low_from_hold_a: assert property (  // [RULE14]
    reg_read && reg_addr == 8'h01
    |=> reg_rdata == $past(g_cell[0].held_r.corr[7:0]))
    else $error("low byte not taken from the snapshot");
  raw_filtered_a: assert property (  // [RULE19]
    wr_live && unc_path
    |=> g_cell[0].live_r.raw == g_cell[0].filt_r)
    else $error("filtered raw value missing from raw registers");
  die_in_step_a: assert property (  // [RULE6]
    dv[DIE_CH] == dv[0])
    else $error("die decimator out of step with cells");
  filt_moves_a: assert property (  // [RULE22]
    wr_live && !unc_path && cfg_r.shift == 3'h0
    |=> g_cell[0].filt_r == $past(g_cell[0].filt_r)
        + 24'($past(g_cell[0].fdiff) >>> 2))
    else $error("lowpass step not shift of difference");

  single_conv_c: cover property (cell_go ##[1:1000] take);
  cont_conv_c: cover property (take && cont_eff ##[1:1000] take);
  aux_conv_c: cover property (aux_go ##[1:1000] aux_ready_r);
  raw_filt_c: cover property (wr_live && unc_path);
endmodule

// File: tb/mod_stream_model.sv
// modulator bitstream model feeding the cell converter back end
`timescale 1ns/10ps
module mod_stream_model (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [7:0] mode,
  output logic      [7:0] mod_bits
);
  logic [1:0] phase_r;

  // four-step pattern counter, one modulator bit per clock
  always_ff @(posedge clock) begin
    if (!resetn) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // mode 1 gives density 3/4 (+half scale), mode 0 gives 1/4 (-half)
  // die bit alternates so the drift term stays near zero
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      mod_bits[i] = mode[i] ? (phase_r != 2'h0) : (phase_r == 2'h0);
    end
    mod_bits[6] = phase_r[0];
  end
endmodule

// File: tb/cell_adc_backend_test.sv
// self-checking bench of the cell converter back end
`timescale 1ns/10ps
`include "cell_adc_map.svh"
module cell_adc_backend_test;
  logic       clock     = 1'b0;
  logic       resetn    = 1'b0;
  logic       reg_write = 1'b0;
  logic       reg_read  = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] cell_mode = 8'h00;
  logic [7:0] mod_bits;
  logic [7:0] reg_rdata;
  logic [7:0] d;
  logic [7:0] h;
  int         err_count = 0;
  int         checks    = 0;
  int         exp_sign[$];
  int         t_prev;
  int         t_conv;

  // 200 MHz clock
  always #2.5 clock = ~clock;

  // modulator rate equals the clock so conversions stay short
  cell_adc_backend #(.NUM_CELLS(6), .MOD_DIV(1)) i_cell_adc_backend (
    .clock(clock), .resetn(resetn), .mod_bits(mod_bits),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));

  mod_stream_model i_mod_stream_model (
    .clock(clock), .resetn(resetn), .mode(cell_mode), .mod_bits(mod_bits));

  task automatic test_done;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // one-cycle read strobe, data taken once the answer has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // signed compare within one count; an X operand must not pass
  function automatic logic [7:0] near(input logic [7:0] a, input logic [7:0] b);
    int x;
    x = int'($signed(a)) - int'($signed(b));
    if ((^{a, b}) === 1'bx) return 8'hXX;
    return (x >= -1 && x <= 1) ? 8'h01 : 8'h00;
  endfunction

  task automatic wait_ready(output int t);
    logic [7:0] s;
    t = 0;
    s = 8'h00;
    while (s[1] !== 1'b1 && t < 3000) begin
      rd(`ADDR_STATUS, s);
      t += 2;
    end
    chk("status", 8'h02, s & 8'h03);
  endtask

  // main sequence
  initial begin
    void'($urandom(32'h40c01849));
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    for (int c = 0; c < 6; c++) begin
      rd(8'(8 * c + `OFS_CORR_H), d); chk("corr_h", 8'h80, d);
      rd(8'(8 * c + `OFS_CORR_L), d); chk("corr_l", 8'h00, d);
      rd(8'(8 * c + `OFS_RAW_H), d);  chk("raw_h", 8'h80, d);
      rd(8'(8 * c + `OFS_RAW_M), d);  chk("raw_m", 8'h00, d);
      rd(8'(8 * c + `OFS_RAW_L), d);  chk("raw_l", 8'h00, d);
      rd(8'(8 * c + `OFS_FILT_H), d); chk("filt_h", 8'h80, d);
    end
    rd(`ADDR_CFG_CELL, d); chk("cfg_cell", 8'h03, d);
    rd(8'h50, d);          chk("unmapped", 8'h00, d);
    // a large drift shift keeps the correction within one count
    wr(`ADDR_TRIM, 8'h0F);
    t_prev = 0;
    for (int code = 0; code < 4; code++) begin
      cell_mode <= 8'($urandom());
      wr(`ADDR_CFG_CELL, 8'(code));
      wr(`ADDR_CTRL, 8'h01);
      rd(8'(`OFS_CORR_H), d); chk("go_preset", 8'h80, d);
      exp_sign.delete();
      for (int c = 0; c < 6; c++) exp_sign.push_back(cell_mode[c] ? 0 : 1);
      wait_ready(t_conv);
      chk("conv_time", 8'h01, 8'(t_conv > t_prev));
      t_prev = t_conv;
      for (int c = 0; c < 6; c++) begin
        rd(8'(8 * c + `OFS_CORR_H), h);
        rd(8'(8 * c + `OFS_CORR_L), d);
        rd(8'(8 * c + `OFS_RAW_H), d);
        chk("corr_sign", 8'(exp_sign[c]), 8'(h[7]));
        chk("raw_sign", 8'(exp_sign[c]), 8'(d[7]));
        chk("corr_vs_raw", 8'h01, near(h, d));
      end
      rd(`ADDR_DIE_H, d); chk("die_done", 8'h01, 8'(d !== 8'h80));
    end
    // lowpass: ratio 32, shortest shift, settle before trusting it
    wr(`ADDR_CFG_CELL, 8'h00);
    wr(`ADDR_DIAG, 8'h01);
    wr(`ADDR_CTRL, 8'h01);
    repeat (3000) @(posedge clock);
    for (int c = 0; c < 6; c++) begin
      rd(8'(8 * c + `OFS_CORR_H), h);
      rd(8'(8 * c + `OFS_CORR_L), d);
      rd(8'(8 * c + `OFS_FILT_H), d);
      chk("filt_vs_corr", 8'h01, near(h, d));
      chk("filt_sign", 8'(exp_sign[c]), 8'(d[7]));
    end
    // both selects: raw path filtered into the raw registers
    wr(`ADDR_DIAG, 8'h03);
    repeat (3000) @(posedge clock);
    rd(8'(`OFS_CORR_H), h);
    rd(8'(`OFS_FILT_H), d); chk("filt_unused", 8'h80, d);
    rd(8'(`OFS_RAW_H), d);
    chk("raw_filt_sign", 8'(exp_sign[0]), 8'(d[7]));
    // auxiliary converter at its own ratio field, single conversion
    wr(`ADDR_CFG_AUX, 8'h00);
    wr(`ADDR_CTRL, 8'h02);
    repeat (400) @(posedge clock);
    rd(`ADDR_STATUS, d); chk("aux_ready", 8'h08, d & 8'h0C);
    rd(`ADDR_AUX_H, h);
    chk("aux_sign", 8'(cell_mode[7] ? 0 : 1), 8'(h[7]));
    test_done();
  end

  // watchdog sized well beyond the expected run
  initial begin
    #300000;
    err_count++;
    $display("MISMATCH watchdog expected done seen hang");
    test_done();
  end
endmodule
